/* logic/async_serial_port.v */
// Full-duplex serial port with break-field send and receive
// Assumes a byte register port with single-cycle write and read strobes
// Operation
// - Break receive error re-arms, flag stays set
// - Break receive trigger reads zero, self-clears
// - Break transmit trigger reads zero, self-clears
// - Inversion keeps transmit pin in serial use
// - Routing bits feed receive pin elsewhere
// - All enables off means stop mode
// - Power off resets the serial circuit
// - Transmit enable off resets transmitter
// - Receive enable off resets receiver
// - Power off forces line and input high
// - Power off clears status and receive buffer
// - Frame start, 7/8 data, parity, stop
// - Bit order applies both directions
// - Inversion select inverts transmit pin
// - Parity even, odd, zero or none
// - Transmit complete after last stop bit, receive complete mid first stop bit
// - Bit rate is divider output halved
`include "async_serial_regs.vh"
module async_serial_port (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  input  wire        i_serial_in_pin,
  input  wire        i_ext_irq_pin,
  input  wire        i_capture_pin,
  output wire        o_serial_out_pin,
  output wire        o_tx_pin_oe,
  output wire        o_tx_pin_serial,
  output wire        o_rx_pin_serial,
  output wire        o_external_irq_input,
  output wire        o_timer_capture_input,
  output reg         o_tx_complete_irq,
  output reg         o_rx_complete_irq
);
  reg [7:0] dir_r, route_r, mode_r, pre_r, div_r, latch_r;
  reg       order_r, inv_r, brk_flag_r, brk_rx_r, brk_tx_r;
  reg [2:0] brk_len_r;
  reg [7:0] txb_r, rxb_r;
  reg       txbf_r, txsf_r;
  reg [2:0] err_r;
  localparam [7:0] CTL_RST = `RST_CONTROL;
  wire power = mode_r[`BIT_POWER];
  wire txe   = power & mode_r[`BIT_TXE];
  wire rxe   = power & mode_r[`BIT_RXE];
  wire [1:0] par = {mode_r[`BIT_PAR_HI], mode_r[`BIT_PAR_LO]};
  wire len8  = mode_r[`BIT_CHAR_LEN];
  wire stop2 = mode_r[`BIT_STOP_LEN];
  wire wr_ctl = i_wr & (i_addr == `ADDR_CONTROL);
  wire wr_txb = i_wr & (i_addr == `ADDR_TX_BUFFER);
  wire rd_sts = i_rd & (i_addr == `ADDR_RX_STATUS);
  // Transmitter state
  localparam T_IDLE = 3'b001, T_SEND = 3'b010, T_BRK = 3'b100;
  reg [2:0]  tst_r;
  reg [11:0] tsh_r;
  reg [4:0]  tcnt_r;
  reg        tline_r;
  wire t_full, r_half;
  // Receiver state
  localparam R_IDLE = 3'b001, R_DATA = 3'b010, R_BRK = 3'b100;
  reg [2:0]  rst_r;
  reg [10:0] rsh_r;
  reg [4:0]  rcnt_r, rbits_r;
  reg        rin_d_r;
  wire rin = power ? i_serial_in_pin : 1'b1;
  bit_timer u_tx_timer (.i_clock(i_clock), .i_rst(i_rst), .i_clear(~txe | tst_r[0]), .i_prescale(pre_r[3:0]),
    .i_divisor(div_r), .o_half(), .o_full(t_full));
  bit_timer u_rx_timer (.i_clock(i_clock), .i_rst(i_rst), .i_clear(~rxe | rst_r[0]), .i_prescale(pre_r[3:0]),
    .i_divisor(div_r), .o_half(r_half), .o_full());
  // Data bits in line order, parity computed on the character
  function [7:0] order_bits(input [7:0] d, input lsb, input l8);
    integer k;
    begin
      order_bits = d;
      if (!lsb) begin
        for (k = 0; k < 8; k = k + 1)
          order_bits[k] = l8 ? d[7-k] : ((k < 7) ? d[6-k] : 1'b0);
      end
    end
  endfunction
  wire [7:0] tdat  = order_bits(txb_r, order_r, len8);
  wire       tpar1 = ^(len8 ? txb_r : {1'b0, txb_r[6:0]});
  wire       tparb = (par == 2'b11) ? ~tpar1 : (par == 2'b10) ? tpar1 : 1'b0;
  wire       haspar = (par != 2'b00);
  wire [4:0] tframe = 5'h1 + (len8 ? 5'h8 : 5'h7) + {4'h0, haspar} + (stop2 ? 5'h2 : 5'h1);
  wire [11:0] tload = len8 ? {2'b11, tparb | ~haspar, tdat, 1'b0} : {3'b111, tparb | ~haspar, tdat[6:0], 1'b0};
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tst_r <= T_IDLE;
      tsh_r <= 12'hFFF;
      tcnt_r <= 5'h00;
      tline_r <= 1'b1;
      txbf_r <= 1'b0;
      txsf_r <= 1'b0;
      txb_r <= 8'h00;
      brk_tx_r <= 1'b0;
      o_tx_complete_irq <= 1'b0;
    end else begin
      o_tx_complete_irq <= 1'b0;
      if (wr_txb)
        txb_r <= i_wdata;
      if (!txe) begin
        tst_r <= T_IDLE;
        tline_r <= 1'b1;
        txbf_r <= 1'b0;
        txsf_r <= 1'b0;
        brk_tx_r <= 1'b0;
      end else begin
        if (wr_ctl && i_wdata[`BIT_BRK_TX] && tst_r == T_IDLE)
          brk_tx_r <= 1'b1;
        if (wr_txb)
          txbf_r <= 1'b1;
        case (tst_r)
          T_IDLE: begin
            if (brk_tx_r) begin
              tst_r <= T_BRK;
              tline_r <= 1'b0;
              tcnt_r <= {1'b0, `BRK_BASE} + {2'b00, brk_len_r - `BRK_OFFS};
            end else if (txbf_r) begin
              tst_r <= T_SEND;
              tsh_r <= {1'b1, tload[11:1]};
              tline_r <= 1'b0;
              tcnt_r <= tframe - 5'h01;
              txbf_r <= wr_txb;
              txsf_r <= 1'b1;
            end
          end
          T_SEND: begin
            if (t_full) begin
              if (tcnt_r == 5'h00) begin
                tst_r <= T_IDLE;
                txsf_r <= 1'b0;
                o_tx_complete_irq <= 1'b1;
              end else begin
                tline_r <= tsh_r[0];
                tsh_r <= {1'b1, tsh_r[11:1]};
                tcnt_r <= tcnt_r - 5'h01;
              end
            end
          end
          T_BRK: begin
            if (t_full) begin
              if (tcnt_r == 5'h01) begin
                tst_r <= T_IDLE;
                tline_r <= 1'b1;
                brk_tx_r <= 1'b0;
                o_tx_complete_irq <= 1'b1;
              end else begin
                tcnt_r <= tcnt_r - 5'h01;
              end
            end
          end
          default: tst_r <= T_IDLE;
        endcase
      end
    end
  end
  wire [4:0] rframe = (len8 ? 5'h8 : 5'h7) + {4'h0, haspar} + 5'h1;
  // Samples taken so far sit at the top; move the start bit down to bit 0
  wire [10:0] ralign = rsh_r >> (5'hB - rframe);
  wire [7:0] rraw  = len8 ? ralign[8:1] : {1'b0, ralign[7:1]};
  wire [7:0] rdat  = order_bits(rraw, order_r, len8);
  wire       rpar  = len8 ? ralign[9] : ralign[8];
  wire       rstop = rin;
  wire       perr  = par[1] & ((^rraw ^ rpar) != par[0]);
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rst_r <= R_IDLE;
      rsh_r <= 11'h000;
      rcnt_r <= 5'h00;
      rbits_r <= 5'h00;
      rin_d_r <= 1'b1;
      rxb_r <= 8'h00;
      err_r <= 3'h0;
      brk_flag_r <= 1'b0;
      brk_rx_r <= 1'b0;
      o_rx_complete_irq <= 1'b0;
    end else begin
      o_rx_complete_irq <= 1'b0;
      rin_d_r <= rin;
      if (rd_sts)
        err_r <= 3'h0;
      if (!power) begin
        rxb_r <= 8'h00;
        err_r <= 3'h0;
        brk_flag_r <= 1'b0;
        brk_rx_r <= 1'b0;
        rst_r <= R_IDLE;
      end else if (!rxe) begin
        rst_r <= R_IDLE;
        brk_flag_r <= 1'b0;
        brk_rx_r <= 1'b0;
      end else begin
        if (wr_ctl && i_wdata[`BIT_BRK_RX] && rst_r == R_IDLE) begin
          brk_rx_r <= 1'b1;
          brk_flag_r <= 1'b1;
        end
        case (rst_r)
          R_IDLE: begin
            if (rin_d_r && !rin) begin
              rst_r <= brk_rx_r ? R_BRK : R_DATA;
              rcnt_r <= 5'h00;
              rbits_r <= 5'h00;
            end
          end
          R_DATA: begin
            if (r_half) begin
              rsh_r <= {rin, rsh_r[10:1]};
              if (rbits_r == 5'h00 && rin) begin
                rst_r <= R_IDLE;
              end else if (rbits_r == rframe) begin
                rst_r <= R_IDLE;
                o_rx_complete_irq <= 1'b1;
                rxb_r <= rdat;
                err_r <= err_r | {perr, ~rstop, 1'b0};
              end
              rbits_r <= rbits_r + 5'h01;
            end
          end
          R_BRK: begin
            if (r_half) begin
              if (rin) begin
                rst_r <= R_IDLE;
                if (rcnt_r >= `BRK_RX_MIN) begin
                  brk_rx_r <= 1'b0;
                  brk_flag_r <= 1'b0;
                  o_rx_complete_irq <= 1'b1;
                end
              end else if (rcnt_r != `BRK_RX_MAX) begin
                rcnt_r <= rcnt_r + 5'h01;
              end
            end
          end
          default: rst_r <= R_IDLE;
        endcase
        if (rst_r == R_BRK && r_half && rin && rcnt_r < `BRK_RX_MIN)
          brk_flag_r <= 1'b1;
      end
    end
  end
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dir_r <= `RST_PORT_DIR;
      route_r <= `RST_ROUTING;
      mode_r <= `RST_MODE;
      pre_r <= `RST_PRESCALE;
      div_r <= `RST_DIVISOR;
      latch_r <= `RST_LATCH;
      brk_len_r <= CTL_RST[4:2];
      order_r <= CTL_RST[`BIT_ORDER];
      inv_r <= CTL_RST[`BIT_INVERT];
    end else if (i_wr) begin
      case (i_addr)
        `ADDR_PORT_DIR:   dir_r <= {4'hF, i_wdata[3:0]};
        `ADDR_ROUTING:    route_r <= {5'h00, i_wdata[2:0]};
        `ADDR_MODE:       mode_r <= i_wdata;
        `ADDR_PRESCALE:   pre_r <= {4'h0, i_wdata[3:0]};
        `ADDR_DIVISOR:    div_r <= i_wdata;
        `ADDR_PORT_LATCH: latch_r <= i_wdata;
        `ADDR_CONTROL: begin
          brk_len_r <= i_wdata[4:2];
          order_r <= i_wdata[`BIT_ORDER];
          inv_r <= i_wdata[`BIT_INVERT];
        end
        default: ;
      endcase
    end
  end
  always @* begin
    case (i_addr)
      `ADDR_PORT_DIR:   o_rdata = dir_r;
      `ADDR_ROUTING:    o_rdata = route_r;
      `ADDR_MODE:       o_rdata = mode_r;
      `ADDR_RX_STATUS:  o_rdata = {5'h00, err_r};
      `ADDR_TX_STATUS:  o_rdata = {6'h00, txbf_r, txsf_r};
      `ADDR_PRESCALE:   o_rdata = pre_r;
      `ADDR_DIVISOR:    o_rdata = div_r;
      `ADDR_PORT_LATCH: o_rdata = latch_r;
      `ADDR_RX_BUFFER:  o_rdata = rxb_r;
      `ADDR_CONTROL:    o_rdata = {brk_flag_r, 2'b00, brk_len_r, order_r, inv_r};
      default:          o_rdata = 8'h00;
    endcase
  end
  // Line is idle high unless transmitting; stop mode hands pins back, the transmit pin only while inversion is off
  wire tline = txe ? tline_r : 1'b1;
  assign o_serial_out_pin = inv_r ? ~tline : tline;
  assign o_tx_pin_serial = txe | inv_r;
  assign o_rx_pin_serial = rxe;
  assign o_tx_pin_oe = o_tx_pin_serial | ~dir_r[0];
  assign o_external_irq_input  = route_r[0] ? i_serial_in_pin : i_ext_irq_pin;
  assign o_timer_capture_input = route_r[1] ? i_serial_in_pin : i_capture_pin;
endmodule // async_serial_port

/* logic/async_serial_regs.vh */
// Register map, field positions and reset values of the serial port
// Assumes a byte-wide register port with a word address and single-cycle strobes
`ifndef ASYNC_SERIAL_REGS_VH
`define ASYNC_SERIAL_REGS_VH
`define ADDR_PORT_DIR      16'hFF21
`define ADDR_ROUTING       16'hFF4F
`define ADDR_MODE          16'hFF50
`define ADDR_RX_STATUS     16'hFF53
`define ADDR_TX_STATUS     16'hFF55
`define ADDR_PRESCALE      16'hFF56
`define ADDR_DIVISOR       16'hFF57
`define ADDR_CONTROL       16'hFF58
`define ADDR_TX_BUFFER     16'hFF59
`define ADDR_RX_BUFFER     16'hFF5A
`define ADDR_PORT_LATCH    16'hFF01
`define RST_PORT_DIR       8'hFF
`define RST_ROUTING        8'h00
`define RST_MODE           8'h01
`define RST_PRESCALE       8'h00
`define RST_DIVISOR        8'hFF
`define RST_CONTROL        8'h16
`define RST_LATCH          8'h00
`define BIT_POWER          7
`define BIT_TXE            6
`define BIT_RXE            5
`define BIT_PAR_HI         4
`define BIT_PAR_LO         3
`define BIT_CHAR_LEN       2
`define BIT_STOP_LEN       1
`define BIT_BRK_FLAG       7
`define BIT_BRK_RX         6
`define BIT_BRK_TX         5
`define BIT_ORDER          1
`define BIT_INVERT         0
`define BRK_BASE           4'hD
`define BRK_OFFS           3'h5
`define BRK_RX_MIN         5'h0B
`define BRK_RX_MAX         5'h1F
`endif

/* logic/bit_timer.v */
// Baud tick generator: prescaler and 8-bit divisor, half-bit ticks
// Assumes synchronous clear and a divisor of at least four
module bit_timer (
  input  wire       i_clock,
  input  wire       i_rst,
  input  wire       i_clear,
  input  wire [3:0] i_prescale,
  input  wire [7:0] i_divisor,
  output reg        o_half,
  output reg        o_full
);
  reg [10:0] pre_r;
  reg [7:0]  cnt_r;
  reg        ph_r;
  wire [10:0] pre_nxt = pre_r + 11'h001;
  wire pre_tick = (i_prescale == 4'h0) ? 1'b1 : (pre_nxt[i_prescale - 4'h1] & ~pre_r[i_prescale - 4'h1]);
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pre_r <= 11'h000;
      cnt_r <= 8'h00;
      ph_r <= 1'b0;
      o_half <= 1'b0;
      o_full <= 1'b0;
    end else if (i_clear) begin
      pre_r <= 11'h000;
      cnt_r <= 8'h00;
      ph_r <= 1'b0;
      o_half <= 1'b0;
      o_full <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      o_half <= 1'b0;
      o_full <= 1'b0;
      if (pre_tick) begin
        if (cnt_r == i_divisor - 8'h01) begin
          cnt_r <= 8'h00;
          ph_r <= ~ph_r;
          o_half <= ~ph_r;
          o_full <= ph_r;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule // bit_timer

/* tb/async_serial_port_properties.sv */
// Checker of port pins, routing and register answers of the serial port
// Assumes binding to async_serial_port; register state is tracked from writes
`include "async_serial_regs.vh"
module async_serial_port_properties (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_serial_in_pin,
  input wire logic        i_ext_irq_pin,
  input wire logic        i_capture_pin,
  input wire logic        o_serial_out_pin,
  input wire logic        o_tx_pin_serial,
  input wire logic        o_rx_pin_serial,
  input wire logic        o_external_irq_input,
  input wire logic        o_timer_capture_input,
  input wire logic        o_tx_complete_irq,
  input wire logic        o_rx_complete_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [7:0] rout_r;
  logic       busy_r;
  logic       pwr_d_r;
  wire        tx_on = mode_r[7] && mode_r[6];
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= `RST_MODE;
      ctrl_r <= `RST_CONTROL;
      rout_r <= `RST_ROUTING;
      busy_r <= 1'b0;
      pwr_d_r <= 1'b0;
    end else begin
      pwr_d_r <= mode_r[7];
      if (i_wr && i_addr == `ADDR_MODE) mode_r <= i_wdata;
      if (i_wr && i_addr == `ADDR_CONTROL) ctrl_r <= i_wdata;
      if (i_wr && i_addr == `ADDR_ROUTING) rout_r <= i_wdata;
      if (!tx_on || o_tx_complete_irq) busy_r <= 1'b0;
      else if (i_wr && (i_addr == `ADDR_TX_BUFFER || (i_addr == `ADDR_CONTROL && i_wdata[5]))) busy_r <= 1'b1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire off2 = !mode_r[7] && !pwr_d_r;
  sequence s_tx_go;
    i_wr && i_addr == `ADDR_TX_BUFFER && tx_on && !busy_r && !ctrl_r[0];
  endsequence
  sequence s_start_low;
    (!o_serial_out_pin)[*4];
  endsequence
  property p_route_irq;
    mode_r[7] |-> o_external_irq_input == (rout_r[0] ? i_serial_in_pin : i_ext_irq_pin);
  endproperty
  property p_route_cap;
    mode_r[7] |-> o_timer_capture_input == (rout_r[1] ? i_serial_in_pin : i_capture_pin);
  endproperty
  property p_trig_zero;
    i_addr == `ADDR_CONTROL |-> o_rdata[6:5] == 2'b00;
  endproperty
  property p_inv_pin;
    ctrl_r[0] |-> o_tx_pin_serial;
  endproperty
  property p_stop;
    mode_r[7:5] == 3'b000 && !ctrl_r[0] |-> !o_tx_pin_serial && !o_rx_pin_serial;
  endproperty
  property p_off_high;
    off2 && !ctrl_r[0] |-> o_serial_out_pin;
  endproperty
  property p_off_quiet;
    off2 |-> !o_tx_complete_irq && !o_rx_complete_irq;
  endproperty
  property p_off_status;
    off2 && (i_addr == `ADDR_TX_STATUS || i_addr == `ADDR_RX_STATUS || i_addr == `ADDR_RX_BUFFER) |-> o_rdata == 8'h00;
  endproperty
  property p_tx_start;
    s_tx_go |-> ##[1:2] s_start_low;
  endproperty
  property p_irq_cause;
    o_tx_complete_irq |-> busy_r ##1 !o_tx_complete_irq;
  endproperty
  a_route_irq: assert property (p_route_irq) else $error("external irq routing wrong");
  a_route_cap: assert property (p_route_cap) else $error("capture routing wrong");
  a_trig_zero: assert property (p_trig_zero) else $error("break trigger read not zero");
  a_inv_pin: assert property (p_inv_pin) else $error("inverted pin left serial use");
  a_stop: assert property (p_stop) else $error("pins kept in stop mode");
  a_off_high: assert property (p_off_high) else $error("line not high at power off");
  a_off_quiet: assert property (p_off_quiet) else $error("interrupt with power off");
  a_off_status: assert property (p_off_status) else $error("status kept at power off");
  a_tx_start: assert property (p_tx_start) else $error("no start bit after buffer write");
  a_irq_cause: assert property (p_irq_cause) else $error("stray complete interrupt");
endmodule // async_serial_port_properties
bind async_serial_port async_serial_port_properties chk (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in_pin(i_serial_in_pin),
  .i_ext_irq_pin(i_ext_irq_pin), .i_capture_pin(i_capture_pin), .o_serial_out_pin(o_serial_out_pin),
  .o_tx_pin_serial(o_tx_pin_serial), .o_rx_pin_serial(o_rx_pin_serial),
  .o_external_irq_input(o_external_irq_input), .o_timer_capture_input(o_timer_capture_input),
  .o_tx_complete_irq(o_tx_complete_irq), .o_rx_complete_irq(o_rx_complete_irq));

/* tb/serial_node_model.sv */
// Remote serial node: samples frames from the port and sends frames to it
// Assumes 8 data bits, no parity, one stop bit, wire bit 0 first
module serial_node_model #(parameter int BIT_CLKS = 8) (
  input  wire logic i_clock,
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_byte;
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] b);
    @(posedge i_clock);
    o_line <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      repeat (BIT_CLKS) @(posedge i_clock);
      o_line <= b[k];
    end
    repeat (BIT_CLKS) @(posedge i_clock);
    o_line <= 1'b1;
  endtask
  // Holds the line low for a whole number of bit times
  task automatic brk(input int bits);
    @(posedge i_clock);
    o_line <= 1'b0;
    repeat (bits * BIT_CLKS) @(posedge i_clock);
    o_line <= 1'b1;
  endtask
  initial begin
    rx_byte = 8'h00;
    forever begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clock);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_CLKS) @(posedge i_clock);
        rx_byte[k] = i_line;
      end
    end
  end
endmodule // serial_node_model

/* tb/async_serial_port_tb_top.sv */
// Testbench of the serial port: reset values, frames both ways, routing, break, power off
// Assumes the remote node model and the register map header
`include "async_serial_regs.vh"
module async_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLKS = 8;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_ext_irq_pin = 1'b0;
  logic        i_capture_pin = 1'b0;
  wire         serial_in;
  wire  [7:0]  o_rdata;
  wire         o_serial_out_pin, o_tx_pin_serial, o_rx_pin_serial, tx_oe;
  wire         o_external_irq_input, o_timer_capture_input, o_tx_complete_irq, o_rx_complete_irq;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [23:0] rv [7] = '{24'hFF21FF, 24'hFF4F00, 24'hFF5001, 24'hFF5600, 24'hFF57FF, 24'hFF5816, 24'hFF0000};
  logic [31:0] rows [5] = '{32'h05165555, 32'h0514366C, 32'h05168787, 32'h05140180, 32'h131637B7};
  async_serial_port dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in_pin(serial_in), .i_ext_irq_pin(i_ext_irq_pin),
    .i_capture_pin(i_capture_pin), .o_serial_out_pin(o_serial_out_pin), .o_tx_pin_oe(tx_oe),
    .o_tx_pin_serial(o_tx_pin_serial), .o_rx_pin_serial(o_rx_pin_serial),
    .o_external_irq_input(o_external_irq_input), .o_timer_capture_input(o_timer_capture_input),
    .o_tx_complete_irq(o_tx_complete_irq), .o_rx_complete_irq(o_rx_complete_irq));
  serial_node_model #(.BIT_CLKS(BIT_CLKS)) node (.i_clock(i_clock), .i_line(o_serial_out_pin), .o_line(serial_in));
  always #5 i_clock = ~i_clock;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    #1 v = o_rdata;
    @(posedge i_clock);
    i_rd <= 1'b0;
    chk8(n, e, v);
  endtask
  task automatic wait_irq(input logic rx, output logic s);
    s = 1'b0;
    for (int k = 0; k < 400 && !s; k++) begin
      @(posedge i_clock);
      #1 s = ((rx ? o_rx_complete_irq : o_tx_complete_irq) === 1'b1);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    logic s;
    int   lo;
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int j = 0; j < 7; j++) rchk(rv[j][23:8], rv[j][7:0], "reset value");
    chk1("pin drive off", 1'b0, tx_oe);
    wr(`ADDR_PORT_DIR, 8'hFE);
    wr(`ADDR_PORT_LATCH, 8'h01);
    #1 chk1("pin drive on", 1'b1, tx_oe);
    wr(`ADDR_DIVISOR, 8'h04);
    for (int j = 0; j < 5; j++) begin
      wr(`ADDR_MODE, rows[j][31:24]);
      wr(`ADDR_CONTROL, rows[j][23:16]);
      wr(`ADDR_MODE, rows[j][31:24] | 8'h80);
      wr(`ADDR_MODE, rows[j][31:24] | 8'hE0);
      wr(`ADDR_TX_BUFFER, rows[j][15:8]);
      wait_irq(1'b0, s);
      chk1("tx complete", 1'b1, s);
      chk8("wire byte", rows[j][7:0], node.rx_byte);
      node.send(rows[j][7:0]);
      wait_irq(1'b1, s);
      chk1("rx complete", 1'b1, s);
      rchk(`ADDR_RX_BUFFER, rows[j][15:8], "receive buffer");
      rchk(`ADDR_RX_STATUS, 8'h00, "rx status");
    end
    node.send(8'h37);
    wait_irq(1'b1, s);
    chk1("parity rx irq", 1'b1, s);
    rchk(`ADDR_RX_STATUS, 8'h04, "parity error");
    wr(`ADDR_ROUTING, 8'h03);
    #1 chk1("irq route", 1'b1, o_external_irq_input);
    chk1("capture route", 1'b1, o_timer_capture_input);
    wr(`ADDR_ROUTING, 8'h00);
    #1 chk1("irq pin", 1'b0, o_external_irq_input);
    chk1("capture pin", 1'b0, o_timer_capture_input);
    wr(`ADDR_CONTROL, 8'h36);
    s = 1'b0;
    lo = 0;
    for (int k = 0; k < 300 && !s; k++) begin
      @(posedge i_clock);
      #1 lo += (o_serial_out_pin === 1'b0);
      s = (o_tx_complete_irq === 1'b1);
    end
    chk1("break irq", 1'b1, s);
    chk1("break length", 1'b1, lo >= 13 * BIT_CLKS && lo <= 13 * BIT_CLKS + 1);
    rchk(`ADDR_CONTROL, 8'h16, "control after break");
    wr(`ADDR_CONTROL, 8'h56);
    rchk(`ADDR_CONTROL, 8'h96, "break rx armed");
    node.brk(5);
    wait_irq(1'b1, s);
    chk1("short break irq", 1'b0, s);
    rchk(`ADDR_CONTROL, 8'h96, "break rx held");
    node.brk(13);
    wait_irq(1'b1, s);
    chk1("break rx irq", 1'b1, s);
    rchk(`ADDR_CONTROL, 8'h16, "break rx done");
    wr(`ADDR_TX_BUFFER, 8'h00);
    repeat (20) @(posedge i_clock);
    wr(`ADDR_MODE, 8'h05);
    repeat (2) @(posedge i_clock);
    #1 chk1("line at power off", 1'b1, o_serial_out_pin);
    rchk(`ADDR_TX_STATUS, 8'h00, "tx status");
    rchk(`ADDR_RX_BUFFER, 8'h00, "rx buffer");
    chk1("tx pin stop", 1'b0, o_tx_pin_serial);
    chk1("rx pin stop", 1'b0, o_rx_pin_serial);
    wr(`ADDR_CONTROL, 8'h17);
    #1 chk1("tx pin inverted", 1'b1, o_tx_pin_serial);
    wr(`ADDR_MODE, 8'h85);
    wr(`ADDR_MODE, 8'hE5);
    repeat (2) @(posedge i_clock);
    #1 chk1("inverted idle", 1'b0, o_serial_out_pin);
    wrap_up();
  end
endmodule // async_serial_port_tb_top
